// File: pkg/ascc_pkg.sv
// register map, field positions, codes and timing counts for the
// converter control block; shared by the design and the bench
// assumes a 32-bit APB register port with word-aligned offsets
package ascc_pkg;

    // byte offsets of the three register words
    localparam logic [7:0] ASCC_CTL_ONE_OFFSET = 8'h00;
    localparam logic [7:0] ASCC_CTL_THREE_OFFSET = 8'h04;
    localparam logic [7:0] ASCC_RESULT_OFFSET = 8'h08;

    // adc_control_one field positions
    localparam int ASCC_ON_BIT = 15;
    localparam int ASCC_STOP_IN_IDLE_BIT = 13;
    localparam int ASCC_OUTPUT_FORMAT_SELECT_LSB = 8;
    localparam int ASCC_CONVERSION_TRIGGER_SELECT_LSB = 5;
    localparam int ASCC_STOP_AFTER_FIRST_INTERRUPT_BIT = 4;
    localparam int ASCC_AUTO_SAMPLE_START_BIT = 2;
    localparam int ASCC_SAMPLE_ENABLE_BIT = 1;
    localparam int ASCC_DONE_BIT = 0;

    // adc_control_three field position (auto_sample_time, 5 bits)
    localparam int ASCC_AUTO_SAMPLE_TIME_LSB = 8;
    localparam int ASCC_AUTO_SAMPLE_TIME_W = 5;

    // reset values of the writable fields and of the result data
    localparam logic [31:0] ASCC_CTL_ONE_RESET = 32'h0000_0000;
    localparam logic [4:0] ASCC_AUTO_SAMPLE_TIME_RESET = 5'h00;
    localparam logic [9:0] ASCC_DATA_RESET = 10'h000;

    // conversion_trigger_select codes
    localparam logic [2:0] ASCC_TRIG_SOFTWARE = 3'h0;
    localparam logic [2:0] ASCC_TRIG_EXT_PIN = 3'h1;
    localparam logic [2:0] ASCC_TRIG_TIMER = 3'h2;
    localparam logic [2:0] ASCC_TRIG_CHARGE = 3'h3;
    localparam logic [2:0] ASCC_TRIG_AUTO = 3'h7;

    // output_format_select codes
    localparam logic [2:0] ASCC_FMT_UINT16 = 3'h0;
    localparam logic [2:0] ASCC_FMT_SINT16 = 3'h1;
    localparam logic [2:0] ASCC_FMT_FRAC16 = 3'h2;
    localparam logic [2:0] ASCC_FMT_SFRAC16 = 3'h3;
    localparam logic [2:0] ASCC_FMT_UINT32 = 3'h4;
    localparam logic [2:0] ASCC_FMT_SINT32 = 3'h5;
    localparam logic [2:0] ASCC_FMT_FRAC32 = 3'h6;
    localparam logic [2:0] ASCC_FMT_SFRAC32 = 3'h7;

    // system clocks per conversion clock period used by auto sampling
    localparam int ASCC_TAD_CYCLES = 2;

    typedef enum logic [1:0] {
        ASCC_IDLE,
        ASCC_SAMPLE,
        ASCC_CONVERT
    } ascc_state_type;

endpackage : ascc_pkg

// File: hw/ascc_control.sv
// sample / convert sequencer of a 10-bit converter, with its APB
// register port and the result formatter
// assumes the analog core answers each conv_start pulse with one
// conv_done pulse and valid conv_data, on sys_clk
//
// Overview of operation
// - module enable runs converter, clear holds inactive
// - stop_in_idle halts block during idle mode
// - format codes 1xx build 32-bit result word
// - format codes 0xx fill low 16 bits
// - trigger 111 uses internal counter; 100-110 reserved
// - triggers 011/010/001: charge unit, timer, pin
// - trigger 000: software clearing sample_enable converts
// - stop_after_first_interrupt clears auto start at interrupt
// - otherwise each conversion overwrites the result
// - auto start resamples right after conversion ends
// - without auto start, writing one starts sampling
// - sample_enable reads one while sampling
// - hardware trigger clears sample_enable itself
// - completion flag set when conversion finishes
// - software clears flag by zero; one ignored
// - completion flag cleared when conversion begins
// - auto_sample_time used only with trigger 111
//
// Added by the designer: the register addresses and register access over APB.
module ascc_control
    import ascc_pkg::*;
#(
    parameter int TAD_CYCLES = ASCC_TAD_CYCLES,
    parameter bit EXT_RISING = 1'b1
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic idle_mode,
    input wire logic ext_int_zero_pin,
    input wire logic timer_period_match,
    input wire logic charge_time_event,
    input wire logic conv_done,
    input wire logic [9:0] conv_data,
    output logic conv_enable,
    output logic sample_hold,
    output logic conv_start,
    output logic adc_interrupt
);

    // control fields of adc_control_one and adc_control_three
    logic ctl_on;
    logic ctl_stop_in_idle;
    logic [2:0] ctl_output_format_select;
    logic [2:0] ctl_conversion_trigger_select;
    logic ctl_stop_after_first_interrupt;
    logic ctl_auto_sample_start;
    logic sample_enable;
    logic done;
    logic [4:0] ctl_auto_sample_time;
    logic [31:0] result;
    ascc_state_type state;
    ascc_state_type next_state;

    // pin synchroniser and edge detector
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;

    // conversion clock divider and sample timer
    logic [7:0] tad_cnt;
    logic [4:0] sample_enable_cnt;

    // format the raw code; signed forms treat mid-scale as zero
    function automatic logic [31:0] fmt_result(input logic [2:0] f, input logic [9:0] d);
        logic s;
        logic [9:0] sd;
        s = ~d[9];
        sd = {s, d[8:0]};
        unique case (f)
            ASCC_FMT_SFRAC32: fmt_result = {sd, 22'h000000};
            ASCC_FMT_FRAC32: fmt_result = {d, 22'h000000};
            ASCC_FMT_SINT32: fmt_result = {{22{s}}, sd};
            ASCC_FMT_UINT32: fmt_result = {22'h000000, d};
            ASCC_FMT_SFRAC16: fmt_result = {16'h0000, sd, 6'h00};
            ASCC_FMT_FRAC16: fmt_result = {16'h0000, d, 6'h00};
            ASCC_FMT_SINT16: fmt_result = {16'h0000, {6{s}}, sd};
            ASCC_FMT_UINT16: fmt_result = {22'h000000, d};
        endcase
    endfunction : fmt_result

    // bus decode; access completes in the cycle after setup
    wire bus_access = psel && penable && pready;
    wire hit_one = paddr == ASCC_CTL_ONE_OFFSET;
    wire hit_three = paddr == ASCC_CTL_THREE_OFFSET;
    wire hit_result = paddr == ASCC_RESULT_OFFSET;
    wire addr_ok = hit_one || hit_three || hit_result;
    wire wr_one = bus_access && pwrite && hit_one;
    wire wr_three = bus_access && pwrite && hit_three;

    // halted only when stopped in idle; running also needs the module enable
    wire halted = ctl_stop_in_idle && idle_mode;
    wire running = ctl_on && !halted;

    // readback words; reserved bits read zero
    wire [31:0] rd_one = {16'h0000, ctl_on, 1'b0, ctl_stop_in_idle, 2'b00, ctl_output_format_select,
                          ctl_conversion_trigger_select, ctl_stop_after_first_interrupt, 1'b0, ctl_auto_sample_start, sample_enable, done};
    wire [31:0] rd_three = {19'h00000, ctl_auto_sample_time, 8'h00};
    wire [31:0] rd_word = hit_one ? rd_one : hit_three ? rd_three : hit_result ? result : 32'h0;

    // software sample-enable writes
    wire sw_sample_enable_set = wr_one && pwdata[ASCC_SAMPLE_ENABLE_BIT] && !ctl_auto_sample_start;
    wire sw_sample_enable_clr = wr_one && !pwdata[ASCC_SAMPLE_ENABLE_BIT]
                       && ctl_conversion_trigger_select == ASCC_TRIG_SOFTWARE;

    // active edge of the synchronised pin
    wire ext_edge = EXT_RISING ? (ext_sync && !ext_prev) : (!ext_sync && ext_prev);

    // auto timer: zero sample time treated as one conversion clock
    wire tad_tick = tad_cnt == 8'(TAD_CYCLES - 1);
    wire [4:0] auto_sample_time_eff = (ctl_auto_sample_time == 5'h00) ? 5'h01 : ctl_auto_sample_time;
    wire auto_end = tad_tick && (sample_enable_cnt + 5'h01 >= auto_sample_time_eff);

    // trigger select; reserved codes never end sampling
    wire hw_trig = (ctl_conversion_trigger_select == ASCC_TRIG_AUTO) ? auto_end
                 : (ctl_conversion_trigger_select == ASCC_TRIG_CHARGE) ? charge_time_event
                 : (ctl_conversion_trigger_select == ASCC_TRIG_TIMER) ? timer_period_match
                 : (ctl_conversion_trigger_select == ASCC_TRIG_EXT_PIN) ? ext_edge : 1'b0;

    // sequencing events
    wire start_sample = running && state == ASCC_IDLE && (sw_sample_enable_set || ctl_auto_sample_start);
    wire trigger = running && state == ASCC_SAMPLE && (sw_sample_enable_clr || hw_trig);
    wire finish = running && state == ASCC_CONVERT && conv_done;

    // next-state decode
    always_comb
    begin
        next_state = state;
        if (!ctl_on)
            next_state = ASCC_IDLE;
        else if (start_sample)
            next_state = ASCC_SAMPLE;
        else if (trigger)
            next_state = ASCC_CONVERT;
        else if (finish)
            next_state = ctl_auto_sample_start && !ctl_stop_after_first_interrupt ? ASCC_SAMPLE : ASCC_IDLE;
    end

    // bus answer, one wait-free access cycle
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= (psel && !penable && !pwrite) ? rd_word : 32'h0;
        end
    end

    // configuration fields written by software
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ctl_on <= ASCC_CTL_ONE_RESET[ASCC_ON_BIT];
            ctl_stop_in_idle <= ASCC_CTL_ONE_RESET[ASCC_STOP_IN_IDLE_BIT];
            ctl_output_format_select <= ASCC_CTL_ONE_RESET[ASCC_OUTPUT_FORMAT_SELECT_LSB +: 3];
            ctl_conversion_trigger_select <= ASCC_CTL_ONE_RESET[ASCC_CONVERSION_TRIGGER_SELECT_LSB +: 3];
            ctl_stop_after_first_interrupt <= ASCC_CTL_ONE_RESET[ASCC_STOP_AFTER_FIRST_INTERRUPT_BIT];
            ctl_auto_sample_time <= ASCC_AUTO_SAMPLE_TIME_RESET;
        end
        else
        begin
            if (wr_one)
            begin
                ctl_on <= pwdata[ASCC_ON_BIT];
                ctl_stop_in_idle <= pwdata[ASCC_STOP_IN_IDLE_BIT];
                ctl_output_format_select <= pwdata[ASCC_OUTPUT_FORMAT_SELECT_LSB +: 3];
                ctl_conversion_trigger_select <= pwdata[ASCC_CONVERSION_TRIGGER_SELECT_LSB +: 3];
                ctl_stop_after_first_interrupt <= pwdata[ASCC_STOP_AFTER_FIRST_INTERRUPT_BIT];
            end
            if (wr_three)
                ctl_auto_sample_time <= pwdata[ASCC_AUTO_SAMPLE_TIME_LSB +: ASCC_AUTO_SAMPLE_TIME_W];
        end
    end

    // auto start: hardware clear at the interrupt beats a software write
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            ctl_auto_sample_start <= ASCC_CTL_ONE_RESET[ASCC_AUTO_SAMPLE_START_BIT];
        else if (finish && ctl_stop_after_first_interrupt)
            ctl_auto_sample_start <= 1'b0;
        else if (wr_one)
            ctl_auto_sample_start <= pwdata[ASCC_AUTO_SAMPLE_START_BIT];
    end

    // sequencer state; sample_enable mirrors the sampling state
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state <= ASCC_IDLE;
            sample_enable <= ASCC_CTL_ONE_RESET[ASCC_SAMPLE_ENABLE_BIT];
        end
        else
        begin
            state <= next_state;
            sample_enable <= next_state == ASCC_SAMPLE;
        end
    end

    // completion flag: hardware set wins over a software clear
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            done <= ASCC_CTL_ONE_RESET[ASCC_DONE_BIT];
        else if (finish)
            done <= 1'b1;
        else if (trigger)
            done <= 1'b0;
        else if (wr_one && !pwdata[ASCC_DONE_BIT])
            done <= 1'b0;
    end

    // result word, overwritten by every finished conversion
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            result <= fmt_result(ASCC_FMT_UINT16, ASCC_DATA_RESET);
        else if (finish)
            result <= fmt_result(ctl_output_format_select, conv_data);
    end

    // core-facing strobes and levels
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            conv_enable <= 1'b0;
            sample_hold <= 1'b0;
            conv_start <= 1'b0;
            adc_interrupt <= 1'b0;
        end
        else
        begin
            conv_enable <= ctl_on;
            sample_hold <= next_state == ASCC_SAMPLE;
            conv_start <= trigger;
            adc_interrupt <= finish;
        end
    end

    // two-flop pin synchroniser; only the second stage is looked at
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end
        else
        begin
            ext_meta <= ext_int_zero_pin;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // conversion clock divider and sample timer, restarted per sample
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || state != ASCC_SAMPLE || !running)
        begin
            tad_cnt <= 8'h00;
            sample_enable_cnt <= 5'h00;
        end
        else if (tad_tick)
        begin
            tad_cnt <= 8'h00;
            sample_enable_cnt <= sample_enable_cnt + 5'h01;
        end
        else
            tad_cnt <= tad_cnt + 8'h01;
    end

    chk_off_no_sample: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !ctl_on |=> !sample_enable && !conv_start)
        else $error("sampling while disabled");

    chk_idle_stop_halts: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctl_stop_in_idle && idle_mode) |=> !conv_start && !adc_interrupt && $stable(state))
        else $error("activity while stopped in idle");

    chk_result_uint16: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (finish && ctl_output_format_select == ASCC_FMT_UINT16) |=> result == {22'h000000, $past(conv_data)})
        else $error("unsigned 16-bit result wrong");

    chk_result_sfrac32: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (finish && ctl_output_format_select == ASCC_FMT_SFRAC32)
        |=> result == {~$past(conv_data[9]), $past(conv_data[8:0]), 22'h000000})
        else $error("signed fractional 32-bit result wrong");

    chk_reserved_no_trig: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctl_conversion_trigger_select inside {3'h4, 3'h5, 3'h6} && !wr_one) |=> !conv_start)
        else $error("reserved trigger started conversion");

    chk_trigger_clears_sample_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
        conv_start |-> !sample_enable && !done && state == ASCC_CONVERT)
        else $error("sample_enable or done left set at conversion start");

    chk_done_with_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(done) |-> adc_interrupt)
        else $error("completion flag without interrupt");

    chk_first_irq_stops: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (finish && ctl_stop_after_first_interrupt) |=> !ctl_auto_sample_start && state == ASCC_IDLE ##1 !sample_enable)
        else $error("auto start not cleared at first interrupt");

    chk_auto_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (finish && ctl_auto_sample_start && !ctl_stop_after_first_interrupt && ctl_on) |=> sample_enable && sample_hold)
        else $error("auto start did not resample");

    chk_done_write_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!done && !finish && wr_one) |=> !done)
        else $error("software write set completion flag");

    chk_start_clears_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
        trigger |=> !done)
        else $error("completion flag kept at conversion start");

endmodule : ascc_control

// File: bench/ascc_core_model.sv
// behavioural analog core on the far side of the converter control
// assumes conv_start is a one-cycle pulse on sys_clk
module ascc_core_model
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic conv_start,
    input wire logic [3:0] delay,
    input wire logic [9:0] sample_value,
    output logic conv_done,
    output logic [9:0] conv_data
);
    logic [3:0] count;
    logic busy;
    logic fin;

    assign fin = busy && count == 4'h0;

    // data toggles outside conv_done so that early use shows up
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            busy <= 1'b0;
            count <= 4'h0;
            conv_done <= 1'b0;
            conv_data <= 10'h000;
        end
        else
        begin
            conv_done <= fin;
            conv_data <= fin ? sample_value : ~conv_data;
            if (conv_start)
            begin
                busy <= 1'b1;
                count <= delay;
            end
            else if (busy)
            begin
                busy <= !fin;
                count <= count - 4'h1;
            end
        end
    end
endmodule : ascc_core_model

// File: bench/tb_adc_sample_convert_control.sv
// self-checking bench: apb tasks drive the converter control block
// assumes the core model answers conv_start after delay+1 cycles
module tb_adc_sample_convert_control
    import ascc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic idle_mode = 1'b0;
    logic ext_pin = 1'b0;
    logic tmr = 1'b0;
    logic cte = 1'b0;
    logic [9:0] sample_val = 10'h000;
    logic [3:0] core_delay = 4'h8;
    logic [31:0] prdata;
    logic pready, pslverr, conv_done, conv_enable, sample_hold, conv_start, adc_interrupt;
    logic [9:0] conv_data;
    logic [31:0] rdat;
    logic err;
    int fails = 0;
    int num_checks = 0;
    int irqs = 0;
    int starts = 0;
    int sc;

    always #5 sys_clk = ~sys_clk;

    // event counters, compared against expected totals
    always @(posedge sys_clk)
    begin
        irqs <= irqs + int'(adc_interrupt === 1'b1);
        starts <= starts + int'(conv_start === 1'b1);
    end

    ascc_control ascc_control_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
        .ext_int_zero_pin(ext_pin), .timer_period_match(tmr), .charge_time_event(cte),
        .conv_done(conv_done), .conv_data(conv_data), .conv_enable(conv_enable),
        .sample_hold(sample_hold), .conv_start(conv_start), .adc_interrupt(adc_interrupt));

    ascc_core_model ascc_core_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .conv_start(conv_start), .delay(core_delay), .sample_value(sample_val),
        .conv_done(conv_done), .conv_data(conv_data));

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one apb transfer; the idle edge before setup keeps strobes single-driven
    // and leaves the cycle after a disabling write free of any access
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no assumed latency: only the watchdog ends a missing answer
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdat, err);
        chk("write error", 32'h0, {31'h0, err});
    endtask : wr

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rdat, err);
        chk(name, exp, rdat);
    endtask : rd

    // b holds stop_in_idle, stop_after_first, auto start, sample, done
    function automatic logic [31:0] ctl(input logic on, input logic [2:0] fmt,
        input logic [2:0] trig, input logic [4:0] b);
        ctl = (32'(on) << ASCC_ON_BIT) | (32'(b[4]) << ASCC_STOP_IN_IDLE_BIT)
            | (32'(fmt) << ASCC_OUTPUT_FORMAT_SELECT_LSB) | (32'(trig) << ASCC_CONVERSION_TRIGGER_SELECT_LSB)
            | (32'(b[3]) << ASCC_STOP_AFTER_FIRST_INTERRUPT_BIT) | (32'(b[2]) << ASCC_AUTO_SAMPLE_START_BIT)
            | (32'(b[1]) << ASCC_SAMPLE_ENABLE_BIT) | 32'(b[0]);
    endfunction : ctl

    // sign is the inverted top bit of the offset-binary sample
    function automatic logic [31:0] fmt_exp(input logic [2:0] f, input logic [9:0] d);
        logic [9:0] s;
        s = {~d[9], d[8:0]};
        case (f)
            3'h0, 3'h4: fmt_exp = {22'h0, d};
            3'h1: fmt_exp = {16'h0, {6{s[9]}}, s};
            3'h2: fmt_exp = {16'h0, d, 6'h00};
            3'h3: fmt_exp = {16'h0, s, 6'h00};
            3'h5: fmt_exp = {{22{s[9]}}, s};
            3'h6: fmt_exp = {d, 22'h0};
            default: fmt_exp = {s, 22'h0};
        endcase
    endfunction : fmt_exp

    // bounded wait for conv_start, or for adc_interrupt when irq is set;
    // at least one edge passes so a pulse already seen is not counted twice
    task automatic wait_out(input bit irq, input int lim);
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (((irq ? adc_interrupt : conv_start) !== 1'b1) && n < lim);
        chk(irq ? "interrupt seen" : "start seen", 32'h1,
            {31'h0, (irq ? adc_interrupt : conv_start) === 1'b1});
    endtask : wait_out

    task automatic sw_conv(input logic [2:0] f, input logic [9:0] v);
        sample_val <= v;
        sc = starts;
        wr(ASCC_CTL_ONE_OFFSET, ctl(1, f, 0, 5'h02));
        rd("sampling", ASCC_CTL_ONE_OFFSET, ctl(1, f, 0, 5'h02));
        chk("enable and hold", 32'h3, {30'h0, conv_enable, sample_hold});
        chk("no early start", 32'(sc), 32'(starts));
        wr(ASCC_CTL_ONE_OFFSET, ctl(1, f, 0, 5'h00));
        wait_out(0, 8);
        wait_out(1, 40);
        rd("done set", ASCC_CTL_ONE_OFFSET, ctl(1, f, 0, 5'h01));
        rd("result", ASCC_RESULT_OFFSET, fmt_exp(f, v));
    endtask : sw_conv

    task automatic hw_conv(input logic [2:0] t);
        // done written as one is ignored, so a done left set must fall at the trigger
        wr(ASCC_CTL_ONE_OFFSET, ctl(1, 0, t, 5'h03));
        @(posedge sys_clk);
        ext_pin <= (t == ASCC_TRIG_EXT_PIN);
        tmr <= (t == ASCC_TRIG_TIMER);
        cte <= (t == ASCC_TRIG_CHARGE);
        @(posedge sys_clk);
        tmr <= 1'b0;
        cte <= 1'b0;
        wait_out(0, 30);
        ext_pin <= 1'b0;
        rd("hw clears sample", ASCC_CTL_ONE_OFFSET, ctl(1, 0, t, 5'h00));
        wait_out(1, 40);
    endtask : hw_conv

    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd("ctl one reset", ASCC_CTL_ONE_OFFSET, 32'h0);
        rd("ctl three reset", ASCC_CTL_THREE_OFFSET, 32'h0);
        rd("result reset", ASCC_RESULT_OFFSET, 32'h0);
        apb(1'b0, 8'h0c, 32'h0, rdat, err);
        chk("unmapped error", 32'h1, {31'h0, err});
        wr(ASCC_CTL_ONE_OFFSET, ctl(0, 0, 0, 5'h02));
        repeat (4) @(posedge sys_clk);
        chk("held off", 32'h0, {30'h0, conv_enable, sample_hold});
        $display("test reset and disable done");
        wr(ASCC_CTL_THREE_OFFSET, 32'h1 << ASCC_AUTO_SAMPLE_TIME_LSB);
        // enable first: a sample request only counts once the block runs
        wr(ASCC_CTL_ONE_OFFSET, ctl(1, 0, 0, 5'h00));
        for (int f = 0; f < 8; f++)
            sw_conv(3'(f), 10'h2a5 ^ 10'(f * 77));
        chk("interrupt count", 32'h8, 32'(irqs));
        wr(ASCC_CTL_ONE_OFFSET, ctl(1, 0, 0, 5'h00));
        wr(ASCC_CTL_ONE_OFFSET, ctl(1, 0, 0, 5'h01));
        rd("done stays clear", ASCC_CTL_ONE_OFFSET, ctl(1, 0, 0, 5'h00));
        $display("test formats done");
        // long auto sample time so the wait starts before the counter ends
        wr(ASCC_CTL_THREE_OFFSET, 32'h5 << ASCC_AUTO_SAMPLE_TIME_LSB);
        hw_conv(ASCC_TRIG_EXT_PIN);
        hw_conv(ASCC_TRIG_TIMER);
        hw_conv(ASCC_TRIG_CHARGE);
        hw_conv(ASCC_TRIG_AUTO);
        // reserved trigger code: events present, sampling must never end
        wr(ASCC_CTL_ONE_OFFSET, ctl(1, 0, 3'h5, 5'h02));
        sc = starts;
        tmr <= 1'b1;
        cte <= 1'b1;
        repeat (30) @(posedge sys_clk);
        tmr <= 1'b0;
        cte <= 1'b0;
        chk("reserved no start", 32'(sc), 32'(starts));
        wr(ASCC_CTL_ONE_OFFSET, 32'h0);
        $display("test triggers done");
        core_delay <= 4'h2;
        sample_val <= 10'h155;
        wr(ASCC_CTL_THREE_OFFSET, 32'h1 << ASCC_AUTO_SAMPLE_TIME_LSB);
        wr(ASCC_CTL_ONE_OFFSET, ctl(1, 4, 7, 5'h04));
        wait_out(1, 40);
        sample_val <= 10'h0aa;
        chk("resample", 32'h1, {31'h0, sample_hold});
        wait_out(1, 40);
        rd("overwrite", ASCC_RESULT_OFFSET, fmt_exp(4, 10'h0aa));
        wr(ASCC_CTL_ONE_OFFSET, 32'h0);
        idle_mode <= 1'b1;
        wr(ASCC_CTL_ONE_OFFSET, ctl(1, 4, 7, 5'h0c));
        wait_out(1, 40);
        sc = starts;
        repeat (30) @(posedge sys_clk);
        chk("stopped after first", 32'(sc), 32'(starts));
        rd("auto start cleared", ASCC_CTL_ONE_OFFSET, ctl(1, 4, 7, 5'h09));
        $display("test auto sample done");
        wr(ASCC_CTL_ONE_OFFSET, 32'h0);
        wr(ASCC_CTL_ONE_OFFSET, ctl(1, 0, 7, 5'h14));
        sc = starts;
        repeat (30) @(posedge sys_clk);
        chk("frozen in idle", 32'(sc), 32'(starts));
        idle_mode <= 1'b0;
        wait_out(0, 40);
        $display("test idle done");
        test_done;
    end

    // watchdog well above the few hundred cycles the tests take
    initial
    begin
        #200000;
        fails++;
        test_done;
    end
endmodule : tb_adc_sample_convert_control
